/* File: design/fpu_pack_add_mul_cfg.svh */
`ifndef FPU_PACK_ADD_MUL_CFG_SVH
`define FPU_PACK_ADD_MUL_CFG_SVH

`define FPU_WORD_W 60
`define FPU_COEF_W 48
`define FPU_EXP_W 11
`define FPU_INCR_W 18
`define FPU_ACC_W 96
`define FPU_SIGN_BIT 59
`define FPU_EXP_LSB 48
`define FPU_EXP_MSB 58
`define FPU_TOP_LSB 48
`define FPU_INF_POS 12'h7FF
`define FPU_INF_NEG 12'h800
`define FPU_IND_POS 12'h3FF
`define FPU_IND_NEG 12'hC00
`define FPU_EXP_MIN (-12'sd1023)
`define FPU_HALF_SHIFT 12'sd48
`define FPU_MUL_EXP_NORM 12'sd47
`define FPU_MUL_EXP_UNNORM 12'sd48
`define FPU_ADD_RND_BIT 47
`define FPU_MUL_RND_BIT 46
`define FPU_NORM_ZERO_CNT 6'h30

`endif

/* File: design/fpu_pack_add_mul_pkg.sv */
package fpu_pack_add_mul_pkg;

    typedef enum logic [3:0] {
        FPU_OP_NORMALIZE,
        FPU_OP_ROUND_NORMALIZE,
        FPU_OP_UNPACK,
        FPU_OP_PACK,
        FPU_OP_MASK,
        FPU_OP_ADD,
        FPU_OP_SUB,
        FPU_OP_LOWER_ADD,
        FPU_OP_LOWER_SUB,
        FPU_OP_ROUND_ADD,
        FPU_OP_ROUND_SUB,
        FPU_OP_MUL,
        FPU_OP_ROUND_MUL
    } fpu_op_t;

    typedef struct packed {
        fpu_op_t op;
        logic [59:0] first_source_operand;
        logic [59:0] second_source_operand;
        logic [17:0] index_increment_reg;
        logic [5:0] six_bit_count_field;
    } fpu_req_t;

    typedef struct packed {
        logic [59:0] dest_operand_reg;
        logic [17:0] index_increment_reg;
        logic incr_write;
        logic error_exit;
    } fpu_resp_t;

    typedef struct packed {
        logic sign;
        logic signed [11:0] exp;
        logic [47:0] mag;
    } fpu_unp_t;

endpackage

/* File: design/fpu_pack_add_mul.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fpu_pack_add_mul_cfg.svh"

module fpu_pack_add_mul
    import fpu_pack_add_mul_pkg::*;
#(
    parameter int WORD_W = `FPU_WORD_W
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire fpu_req_t req,
    output logic resp_valid,
    output fpu_resp_t resp
);

    if (WORD_W != `FPU_WORD_W)
    begin : g_width_check
        $error("fpu_pack_add_mul serves only a 60-bit word");
    end

    function automatic fpu_unp_t unpack_f(input logic [59:0] w);
        fpu_unp_t u;
        logic [59:0] p;
        logic [10:0] oc;
        p = w[`FPU_SIGN_BIT] ? ~w : w;
        oc = {~p[`FPU_EXP_MSB], p[`FPU_EXP_MSB-1:`FPU_EXP_LSB]};
        u.sign = w[`FPU_SIGN_BIT];
        // One's complement to two's complement: negative values gain one.
        u.exp = $signed({oc[10], oc}) + $signed({11'h000, oc[10]});
        u.mag = p[`FPU_COEF_W-1:0];
        return u;
    endfunction

    // Exponents beyond eleven bits wrap; no overflow test is made here.
    function automatic logic [59:0] pack_f(input logic s,
                                           input logic signed [11:0] e,
                                           input logic [47:0] m);
        logic [11:0] t;
        logic [59:0] w;
        t = e[11] ? 12'(e - 12'sd1) : e;
        w = {1'b0, ~t[10], t[9:0], m};
        return s ? ~w : w;
    endfunction

    function automatic logic [5:0] lead_zero(input logic [48:0] v);
        logic [5:0] r;
        r = 6'h31;
        for (int i = 0; i < 49; i++)
        begin
            if (v[i])
            begin
                r = 6'(48 - i);
            end
        end
        return r;
    endfunction

    fpu_unp_t uj;
    fpu_unp_t uk;
    fpu_unp_t uk_eff;
    fpu_unp_t opa;
    fpu_unp_t opb;
    fpu_resp_t res_d;
    fpu_resp_t res_q;
    logic valid_q;
    logic special;
    logic [11:0] top12;
    logic [48:0] nrm_v;
    logic [48:0] nrm_sh;
    logic [5:0] nrm_lz;
    logic signed [11:0] nrm_e;
    logic is_sub;
    logic is_rnd_add;
    logic j_big;
    logic signed [11:0] diff;
    logic rb_a;
    logic rb_b;
    logic [95:0] acc_a;
    logic [95:0] acc_b;
    logic [96:0] sum97;
    logic [95:0] sum96;
    logic sum_sign;
    logic signed [11:0] sum_e;
    logic [95:0] prod;
    logic [95:0] prod_sh;
    logic signed [11:0] prod_e;
    logic both_norm;
    logic [10:0] pk_exp;
    logic [10:0] unp_oc;

    always_comb
    begin
        uj = unpack_f(req.first_source_operand);
        uk = unpack_f(req.second_source_operand);
        is_sub = req.op inside {FPU_OP_SUB, FPU_OP_LOWER_SUB,
                                FPU_OP_ROUND_SUB};
        is_rnd_add = req.op inside {FPU_OP_ROUND_ADD, FPU_OP_ROUND_SUB};
        uk_eff = uk;
        uk_eff.sign = uk.sign ^ is_sub;
        both_norm = uj.mag[`FPU_COEF_W-1] & uk.mag[`FPU_COEF_W-1];
        top12 = req.second_source_operand[59:`FPU_TOP_LSB];
        special = top12 inside {`FPU_INF_POS, `FPU_INF_NEG,
                                `FPU_IND_POS, `FPU_IND_NEG};

        // Normalize: the round bit sits just below the coefficient.
        nrm_v = {uk.mag, req.op == FPU_OP_ROUND_NORMALIZE};
        nrm_lz = lead_zero(nrm_v);
        if (nrm_lz > `FPU_NORM_ZERO_CNT)
        begin
            nrm_lz = `FPU_NORM_ZERO_CNT;
        end
        nrm_sh = nrm_v << nrm_lz;
        nrm_e = 12'(uk.exp - $signed({6'h00, nrm_lz}));

        // Add and subtract: operand a has the larger exponent.
        j_big = uj.exp >= uk_eff.exp;
        opa = j_big ? uj : uk_eff;
        opb = j_big ? uk_eff : uj;
        diff = 12'(opa.exp - opb.exp);
        // Subtract flips the second sign first, so like signs become
        // unlike and both rounded forms share one test.
        rb_a = is_rnd_add;
        rb_b = is_rnd_add && (diff != 12'sd0) &&
               (both_norm || (uj.sign != uk_eff.sign));
        acc_a = {opa.mag, rb_a, 47'h0000_0000_0000};
        acc_b = {opb.mag, rb_b, 47'h0000_0000_0000} >> $unsigned(diff);
        if (opa.sign == opb.sign)
        begin
            sum97 = {1'b0, acc_a} + {1'b0, acc_b};
            sum_sign = opa.sign;
        end
        else if (acc_a >= acc_b)
        begin
            sum97 = {1'b0, acc_a - acc_b};
            sum_sign = opa.sign;
        end
        else
        begin
            sum97 = {1'b0, acc_b - acc_a};
            sum_sign = opb.sign;
        end
        sum96 = sum97[96] ? sum97[96:1] : sum97[95:0];
        sum_e = 12'(opa.exp + $signed({11'h000, sum97[96]}));

        // Multiply.
        prod = uj.mag * uk.mag;
        if (req.op == FPU_OP_ROUND_MUL)
        begin
            prod = prod + (96'h1 << `FPU_MUL_RND_BIT);
        end
        if (both_norm && !prod[95])
        begin
            prod_sh = prod << 1;
            prod_e = 12'(uj.exp + uk.exp + `FPU_MUL_EXP_NORM);
        end
        else
        begin
            prod_sh = prod;
            prod_e = 12'(uj.exp + uk.exp + `FPU_MUL_EXP_UNNORM);
        end

        pk_exp = req.second_source_operand[59] ?
            {req.index_increment_reg[10], ~req.index_increment_reg[9:0]} :
            {~req.index_increment_reg[10], req.index_increment_reg[9:0]};
        // The increment keeps the one's complement form, not two's.
        unp_oc = req.second_source_operand[59] ?
            {req.second_source_operand[58],
             ~req.second_source_operand[57:48]} :
            {~req.second_source_operand[58],
             req.second_source_operand[57:48]};

        res_d = '0;
        unique case (req.op)
            FPU_OP_NORMALIZE, FPU_OP_ROUND_NORMALIZE:
            begin
                if (special)
                begin
                    res_d.dest_operand_reg = req.second_source_operand;
                    res_d.incr_write = 1'b1;
                    res_d.error_exit = 1'b1;
                end
                else
                begin
                    res_d.incr_write = 1'b1;
                    res_d.index_increment_reg = {12'h000, nrm_lz};
                    // Underflow and a vanished coefficient both clear
                    // the result regardless of sign.
                    if (nrm_e >= `FPU_EXP_MIN && nrm_sh[48:1] != '0)
                    begin
                        res_d.dest_operand_reg =
                            pack_f(uk.sign, nrm_e, nrm_sh[48:1]);
                    end
                end
            end
            FPU_OP_UNPACK:
            begin
                res_d.dest_operand_reg =
                    {{12{uk.sign}},
                     req.second_source_operand[47:0]};
                res_d.index_increment_reg =
                    {{7{unp_oc[10]}}, unp_oc};
                res_d.incr_write = 1'b1;
            end
            FPU_OP_PACK:
            begin
                res_d.dest_operand_reg =
                    {req.second_source_operand[59], pk_exp,
                     req.second_source_operand[47:0]};
            end
            FPU_OP_MASK:
            begin
                res_d.dest_operand_reg =
                    ~({WORD_W{1'b1}} >> req.six_bit_count_field);
            end
            FPU_OP_ADD, FPU_OP_SUB, FPU_OP_ROUND_ADD, FPU_OP_ROUND_SUB:
            begin
                res_d.dest_operand_reg =
                    pack_f(sum_sign, sum_e, sum96[95:48]);
            end
            FPU_OP_LOWER_ADD, FPU_OP_LOWER_SUB:
            begin
                res_d.dest_operand_reg = pack_f(sum_sign,
                    12'(sum_e - `FPU_HALF_SHIFT), sum96[47:0]);
            end
            FPU_OP_MUL, FPU_OP_ROUND_MUL:
            begin
                res_d.dest_operand_reg = pack_f(uj.sign ^ uk.sign, prod_e,
                    prod_sh[95:48]);
            end
            default:
            begin
                res_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            valid_q <= 1'b0;
        end
        else
        begin
            valid_q <= req_valid;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            res_q <= '0;
        end
        else if (req_valid)
        begin
            res_q <= res_d;
        end
    end

    assign resp_valid = valid_q;
    assign resp = res_q;

endmodule

`default_nettype wire

/* File: dv/fpu_pack_add_mul_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module fpu_pack_add_mul_checker
    import fpu_pack_add_mul_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire fpu_req_t req,
    input wire logic resp_valid,
    input wire fpu_resp_t resp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic [59:0] kw;
    logic [17:0] bw;
    logic special;
    logic [48:0] isum;
    logic [10:0] pexp;
    assign kw = req.second_source_operand;
    assign bw = req.index_increment_reg;
    assign special = kw[59:48] inside {12'h7FF, 12'h800, 12'h3FF, 12'hC00};
    assign isum = {1'b0, req.first_source_operand[47:0]} + {1'b0, kw[47:0]};
    assign pexp = kw[59] ? {bw[10], ~bw[9:0]} : {~bw[10], bw[9:0]};
    a_answer_next: assert property (req_valid |=> resp_valid)
        else $error("answer missing one cycle after request");
    a_no_spurious: assert property (!req_valid |=> !resp_valid)
        else $error("answer without request");
    a_result_hold: assert property (!req_valid |=> $stable(resp))
        else $error("result changed without request");
    a_special_copy: assert property (req_valid && special &&
        req.op inside {FPU_OP_NORMALIZE, FPU_OP_ROUND_NORMALIZE} |=>
        resp.dest_operand_reg == $past(kw) && resp.error_exit &&
        resp.incr_write && resp.index_increment_reg == 18'h0_0000)
        else $error("special operand not copied");
    a_unpack_coef: assert property (req_valid &&
        req.op == FPU_OP_UNPACK |=> resp.incr_write &&
        resp.dest_operand_reg[47:0] == $past(kw[47:0]))
        else $error("unpack coefficient wrong");
    a_pack_coef: assert property (req_valid && req.op == FPU_OP_PACK |=>
        resp.dest_operand_reg[47:0] == $past(kw[47:0]) &&
        resp.dest_operand_reg[59] == $past(kw[59]))
        else $error("pack coefficient wrong");
    a_pack_exp: assert property (req_valid && req.op == FPU_OP_PACK |=>
        resp.dest_operand_reg[58:48] == $past(pexp))
        else $error("pack exponent wrong");
    a_mask_zero: assert property (req_valid && req.op == FPU_OP_MASK &&
        req.six_bit_count_field == 6'h00 |=> resp.dest_operand_reg == 60'h0)
        else $error("empty mask not zero");
    a_mask_top: assert property (req_valid && req.op == FPU_OP_MASK &&
        req.six_bit_count_field inside {[6'h01:6'h3B]} |=>
        resp.dest_operand_reg[59] && !resp.dest_operand_reg[0])
        else $error("mask not filled from the top");
    a_int_add: assert property (req_valid && req.op == FPU_OP_ADD &&
        req.first_source_operand[59:48] == 12'h400 &&
        kw[59:48] == 12'h400 && !isum[48] |=>
        resp.dest_operand_reg == {12'h400, $past(isum[47:0])})
        else $error("zero exponent add not integer");
endmodule
bind fpu_pack_add_mul fpu_pack_add_mul_checker fpu_pack_add_mul_checker_inst (
    .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
    .resp_valid(resp_valid), .resp(resp));
`default_nettype wire

/* File: dv/fpu_issue_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpu_issue_model
    import fpu_pack_add_mul_pkg::*;
(
    input wire logic clk,
    output logic req_valid,
    output fpu_req_t req,
    input wire logic resp_valid,
    input wire fpu_resp_t resp
);
    initial
    begin
        req_valid = 1'b0;
        req = '0;
    end
    // Operands are scrambled once released so a stale value is never seen.
    task automatic issue(input fpu_req_t q, output fpu_resp_t got,
                         output logic v);
        @(negedge clk);
        req <= q;
        req_valid <= 1'b1;
        @(negedge clk);
        req <= ~q;
        req_valid <= 1'b0;
        v = resp_valid;
        got = resp;
    endtask
endmodule
`default_nettype wire

/* File: dv/fpu_pack_add_mul_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fpu_pack_add_mul_test
    import fpu_pack_add_mul_pkg::*;
;
    logic clk;
    logic arst_n;
    logic req_valid;
    logic resp_valid;
    fpu_req_t req;
    fpu_resp_t resp;
    fpu_resp_t r;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    fpu_pack_add_mul fpu_pack_add_mul_inst (.clk(clk), .arst_n(arst_n),
        .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
        .resp(resp));
    fpu_issue_model fpu_issue_model_inst (.clk(clk), .req_valid(req_valid),
        .req(req), .resp_valid(resp_valid), .resp(resp));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic conclude;
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk_word(input logic [59:0] got, input logic [59:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected word at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic chk_incr(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected incr at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic run(input fpu_op_t op, input logic [59:0] j, k,
                       input logic [17:0] b, input logic [5:0] c);
        logic v;
        fpu_issue_model_inst.issue('{op, j, k, b, c}, r, v);
        chk_incr({17'h0_0000, v}, 18'h0_0001);
    endtask
    task automatic row(input fpu_op_t op, input logic [59:0] j, k, e);
        run(op, j, k, 18'h0_0000, 6'h00);
        chk_word(r.dest_operand_reg, e);
    endtask
    task automatic special_cases;
        logic [11:0] tops [4] = '{12'h7FF, 12'h800, 12'h3FF, 12'hC00};
        foreach (tops[i])
        begin
            run(i % 2 ? FPU_OP_ROUND_NORMALIZE : FPU_OP_NORMALIZE, 60'h0,
                {tops[i], 48'h1234}, 18'h0_0155, 6'h00);
            chk_word(r.dest_operand_reg, {tops[i], 48'h1234});
            chk_incr(r.index_increment_reg, 18'h0_0000);
        end
    endtask
    task automatic normalize_cases;
        run(FPU_OP_NORMALIZE, 60'h0, 60'h400_0000_0000_0001, 18'h0, 6'h00);
        chk_word(r.dest_operand_reg, 60'h3D0_8000_0000_0000);
        chk_incr(r.index_increment_reg, 18'h0_002F);
        row(FPU_OP_ROUND_NORMALIZE, 60'h0, 60'h400_0000_0000_0001,
            60'h3D0_C000_0000_0000);
        row(FPU_OP_ROUND_NORMALIZE, 60'h0, 60'h400_0000_0000_0000,
            60'h3CF_8000_0000_0000);
    endtask
    task automatic unpack_pack_cases;
        row(FPU_OP_UNPACK, 60'h0, 60'h403_0000_0000_0005, 60'h5);
        chk_incr(r.index_increment_reg, 18'h0_0003);
        row(FPU_OP_UNPACK, 60'h0, 60'hBFC_FFFF_FFFF_FFFA,
            60'hFFF_FFFF_FFFF_FFFA);
        chk_incr(r.index_increment_reg, 18'h0_0003);
        row(FPU_OP_UNPACK, 60'h0, 60'h3FE_0000_0000_0001, 60'h1);
        chk_incr(r.index_increment_reg, 18'h3_FFFE);
        run(FPU_OP_PACK, 60'h0, 60'h7FF_0000_0000_0005, 18'h3_F803, 6'h00);
        chk_word(r.dest_operand_reg, 60'h403_0000_0000_0005);
        run(FPU_OP_PACK, 60'h0, 60'hFFF_FFFF_FFFF_FFFA, 18'h0_0003, 6'h00);
        chk_word(r.dest_operand_reg, 60'hBFC_FFFF_FFFF_FFFA);
        run(FPU_OP_PACK, 60'h0, 60'h5, 18'h0_03FF, 6'h00);
        chk_word(r.dest_operand_reg, 60'h7FF_0000_0000_0005);
    endtask
    task automatic mask_cases;
        logic [5:0] counts [6] = '{6'h00, 6'h01, 6'h0C, 6'h3B, 6'h3C, 6'h3F};
        logic [59:0] masks [6] = '{60'h0, 60'h800_0000_0000_0000,
            60'hFFF_0000_0000_0000, 60'hFFF_FFFF_FFFF_FFFE,
            60'hFFF_FFFF_FFFF_FFFF, 60'hFFF_FFFF_FFFF_FFFF};
        foreach (counts[i])
        begin
            run(FPU_OP_MASK, 60'h0, 60'h0, 18'h0_0000, counts[i]);
            chk_word(r.dest_operand_reg, masks[i]);
        end
    endtask
    task automatic arith_cases;
        row(FPU_OP_ADD, 60'h400_0000_0000_0005, 60'h400_0000_0000_0003,
            60'h400_0000_0000_0008);
        row(FPU_OP_SUB, 60'h400_0000_0000_0005, 60'h400_0000_0000_0003,
            60'h400_0000_0000_0002);
        row(FPU_OP_ADD, 60'h400_8000_0000_0000, 60'h400_8000_0000_0000,
            60'h401_8000_0000_0000);
        row(FPU_OP_ADD, 60'h401_0000_0000_0004, 60'h400_0000_0000_0007,
            60'h401_0000_0000_0007);
        row(FPU_OP_LOWER_ADD, 60'h401_0000_0000_0004, 60'h400_0000_0000_0007,
            60'h3D0_8000_0000_0000);
        row(FPU_OP_SUB, 60'h401_0000_0000_0004, 60'h400_0000_0000_0003,
            60'h401_0000_0000_0002);
        row(FPU_OP_LOWER_SUB, 60'h401_0000_0000_0004, 60'h400_0000_0000_0003,
            60'h3D0_8000_0000_0000);
        row(FPU_OP_ROUND_ADD, 60'h401_0000_0000_0002, 60'h400_0000_0000_0003,
            60'h401_0000_0000_0004);
        row(FPU_OP_ROUND_ADD, 60'h400_0000_0000_0005, 60'h400_0000_0000_0003,
            60'h400_0000_0000_0008);
        row(FPU_OP_ROUND_SUB, 60'h401_0000_0000_0004, 60'h400_0000_0000_0003,
            60'h401_0000_0000_0002);
        row(FPU_OP_MUL, 60'h400_0000_0000_0002, 60'h400_0000_0000_0003,
            60'h430_0000_0000_0000);
        row(FPU_OP_MUL, 60'h400_8000_0000_0000, 60'h400_8000_0000_0000,
            60'h42F_8000_0000_0000);
        row(FPU_OP_MUL, 60'h400_0000_00C0_0000, 60'h400_0000_0100_0000,
            60'h430_0000_0000_0000);
        row(FPU_OP_ROUND_MUL, 60'h400_0000_00C0_0000, 60'h400_0000_0100_0000,
            60'h430_0000_0000_0001);
    endtask
    initial
    begin
        arst_n = 1'b0;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        special_cases();
        normalize_cases();
        unpack_pack_cases();
        mask_cases();
        arith_cases();
        conclude();
    end
endmodule
`default_nettype wire
